//--- hdl/lpewc_consts.vh
/*
 Constants of the low-power entry and wake controller: register offsets,
 field positions, reset values and timing figures.
 Assumes a 10 MHz system clock and word-aligned AHB-Lite register access.
*/
`ifndef LPEWC_CONSTS_VH
`define LPEWC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LPEWC_OFS_PWR_CFG    8'h00
`define LPEWC_OFS_ACT_CFG    8'h04
`define LPEWC_OFS_ACT_TMO    8'h08
`define LPEWC_OFS_CTRL       8'h0C
`define LPEWC_OFS_STATUS     8'h10
`define LPEWC_OFS_SETTINGS   8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPEWC_PWR_MASTER     7
`define LPEWC_PWR_IGN_EN     2
`define LPEWC_PWR_WAKE_SEL   1
`define LPEWC_ACT_EN_A       7
`define LPEWC_ACT_EN_B       5
`define LPEWC_ACT_LONG       4
`define LPEWC_CTRL_START     0
`define LPEWC_CTRL_DONE      1
`define LPEWC_CTRL_VSEL      2
`define LPEWC_CTRL_PWR       3
`define LPEWC_CTRL_CLR_STOP  4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPEWC_PWR_CFG_RST    8'h80
`define LPEWC_ACT_CFG_RST    8'h00
`define LPEWC_SETTINGS_RST   16'h0000
`define LPEWC_ACT_TO_SHORT   8'h1B
`define LPEWC_ACT_TO_LONG    8'h6E

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPEWC_CLK_NS         100
`define LPEWC_RX_WAKE_NS     128000
`define LPEWC_ALERT_MS       2000
`define LPEWC_DEBOUNCE_US    10
`define LPEWC_WAKE_SHORT_MS  1
`define LPEWC_WAKE_LONG_MS   5
`define LPEWC_ACT_TICK_US    655360

`endif

//--- hdl/lpewc_top.v
/*
 Low-power entry and wake controller with AHB-Lite register slave,
 ignition debounce, activity monitor, busy/request-to-send handshake.
 Assumes pins are asynchronous to MCLK_I and one AHB-Lite master.
*/
`timescale 1ns/100ps
`include "lpewc_consts.vh"

module lpewc_top
#(
   parameter integer DEB_CYC   = `LPEWC_DEBOUNCE_US * 1000 / `LPEWC_CLK_NS,
   parameter integer ALERT_CYC = `LPEWC_ALERT_MS * 1000000 / `LPEWC_CLK_NS,
   parameter integer WAKE_S    = `LPEWC_WAKE_SHORT_MS * 1000000 / `LPEWC_CLK_NS,
   parameter integer WAKE_L    = `LPEWC_WAKE_LONG_MS * 1000000 / `LPEWC_CLK_NS,
   parameter integer TICK_CYC  = `LPEWC_ACT_TICK_US * 1000 / `LPEWC_CLK_NS
)
(
   input  wire        MCLK_I,
   input  wire        RST_I,
   input  wire        HSEL_I,
   input  wire [31:0] HADDR_I,
   input  wire [1:0]  HTRANS_I,
   input  wire        HWRITE_I,
   input  wire [2:0]  HSIZE_I,
   input  wire [31:0] HWDATA_I,
   input  wire        HREADY_I,
   output reg  [31:0] HRDATA_O,
   output reg         HREADYOUT_O,
   output reg         HRESP_O,
   input  wire        IGN_MON_I,
   input  wire        RTS_N_I,
   input  wire        RXD_I,
   input  wire [3:0]  OBD_ACT_I,
   output reg         BUS_OFF_O,
   output reg         VSEL_O,
   output reg         PWR_CTL_O,
   output reg         BUSY_O,
   output reg         LOW_PWR_O,
   output reg         LOW_POWER_ALERT_MESSAGE_O,
   output reg         STOPPED_O,
   output reg         PROT_CLOSE_O,
   output reg         WAKE_RST_O,
   output reg  [15:0] SETTINGS_O,
   output reg  [3:0]  PROTOCOL_O,
   output reg  [7:0]  BAUD_O
);

   localparam integer RX_CYC = (`LPEWC_RX_WAKE_NS + `LPEWC_CLK_NS - 1) / `LPEWC_CLK_NS;

   localparam [2:0] ST_FULL  = 3'h0;
   localparam [2:0] ST_ALERT = 3'h1;
   localparam [2:0] ST_LOW   = 3'h2;
   localparam [2:0] ST_WAKE  = 3'h3;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg  [6:0]  sync1;
   reg  [6:0]  sync2;
   wire        ign_s;
   wire        rts_n_s;
   wire        rxd_s;
   wire        obd_any;

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         sync1 <= 7'h07;
         sync2 <= 7'h07;
      end
      else
      begin
         sync1 <= {OBD_ACT_I, RXD_I, RTS_N_I, IGN_MON_I};
         sync2 <= sync1;
      end
   end

   assign ign_s   = sync2[0];
   assign rts_n_s = sync2[1];
   assign rxd_s   = sync2[2];
   assign obd_any = |sync2[6:3];

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   reg         wr_pend;
   reg  [7:0]  wr_addr;
   reg  [31:0] rd_mux;
   wire        take;
   wire        wr_cfg;
   wire        wr_act;
   wire        wr_tmo;
   wire        wr_ctl;
   wire        wr_set;

   reg  [7:0]  pwr_cfg;
   reg  [7:0]  act_cfg;
   reg  [7:0]  act_tmo;
   reg         act_ovr;
   reg  [2:0]  state;
   reg         busy;
   reg         stop_flag;
   reg  [7:0]  act_cnt;
   reg         vsel_sw;
   reg         pwr_sw;

   assign take   = HSEL_I & HTRANS_I[1] & HREADY_I;
   assign wr_cfg = wr_pend & (wr_addr == `LPEWC_OFS_PWR_CFG);
   assign wr_act = wr_pend & (wr_addr == `LPEWC_OFS_ACT_CFG);
   assign wr_tmo = wr_pend & (wr_addr == `LPEWC_OFS_ACT_TMO);
   assign wr_ctl = wr_pend & (wr_addr == `LPEWC_OFS_CTRL);
   assign wr_set = wr_pend & (wr_addr == `LPEWC_OFS_SETTINGS);

   always @*
   begin
      case (HADDR_I[7:0])
         `LPEWC_OFS_PWR_CFG:  rd_mux = {24'h000000, pwr_cfg};
         `LPEWC_OFS_ACT_CFG:  rd_mux = {24'h000000, act_cfg};
         `LPEWC_OFS_ACT_TMO:  rd_mux = {24'h000000, act_tmo};
         `LPEWC_OFS_CTRL:     rd_mux = {28'h0000000, pwr_sw, vsel_sw, 2'h0};
         `LPEWC_OFS_STATUS:   rd_mux = {16'h0000, act_cnt, 1'b0, state,
                                        stop_flag, busy, ign_s, LOW_PWR_O};
         `LPEWC_OFS_SETTINGS: rd_mux = {4'h0, BAUD_O, PROTOCOL_O, SETTINGS_O};
         default:             rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         wr_pend     <= 1'b0;
         wr_addr     <= 8'h00;
         HRDATA_O    <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end
      else
      begin
         wr_pend     <= take & HWRITE_I;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
         if (take)
            wr_addr <= HADDR_I[7:0];
         if (take & ~HWRITE_I)
            HRDATA_O <= rd_mux;
      end
   end

   // ----------------------------------------
   // Configuration and retained settings
   // ----------------------------------------
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         pwr_cfg    <= `LPEWC_PWR_CFG_RST;
         act_cfg    <= `LPEWC_ACT_CFG_RST;
         act_tmo    <= 8'h00;
         act_ovr    <= 1'b0;
         vsel_sw    <= 1'b0;
         pwr_sw     <= 1'b0;
         SETTINGS_O <= `LPEWC_SETTINGS_RST;
         PROTOCOL_O <= 4'h0;
         BAUD_O     <= 8'h00;
      end
      else
      begin
         if (wr_cfg)
            pwr_cfg <= HWDATA_I[7:0];
         if (wr_act)
            act_cfg <= HWDATA_I[7:0];
         if (wr_tmo)
         begin
            act_tmo <= HWDATA_I[7:0];
            act_ovr <= 1'b1;
         end
         if (wr_ctl)
         begin
            vsel_sw <= HWDATA_I[`LPEWC_CTRL_VSEL];
            pwr_sw  <= HWDATA_I[`LPEWC_CTRL_PWR];
         end
         // Kept untouched by entry and wake
         if (wr_set)
         begin
            SETTINGS_O <= HWDATA_I[15:0];
            PROTOCOL_O <= HWDATA_I[19:16];
            BAUD_O     <= HWDATA_I[27:20];
         end
      end
   end

   // ----------------------------------------
   // Ignition debounce
   // ----------------------------------------
   reg  [31:0] deb_cnt;
   reg         ign_db;
   reg         ign_db_d;
   wire        ign_fall;

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         deb_cnt  <= 32'h00000000;
         ign_db   <= 1'b1;
         ign_db_d <= 1'b1;
      end
      else
      begin
         ign_db_d <= ign_db;
         if (ign_s == ign_db)
            deb_cnt <= 32'h00000000;
         else if (deb_cnt >= DEB_CYC - 1)
         begin
            ign_db  <= ign_s;
            deb_cnt <= 32'h00000000;
         end
         else
            deb_cnt <= deb_cnt + 32'h00000001;
      end
   end

   assign ign_fall = ign_db_d & ~ign_db;

   // ----------------------------------------
   // Activity monitor
   // ----------------------------------------
   reg  [31:0] tick_cnt;
   wire [7:0]  act_lim;
   wire        act_en;
   wire        act_exp;

   assign act_lim = act_ovr ? act_tmo :
                    (act_cfg[`LPEWC_ACT_LONG] ? `LPEWC_ACT_TO_LONG : `LPEWC_ACT_TO_SHORT);
   assign act_en  = act_cfg[`LPEWC_ACT_EN_A] & act_cfg[`LPEWC_ACT_EN_B]
                  & pwr_cfg[`LPEWC_PWR_MASTER];
   assign act_exp = (act_lim != 8'h00) & (act_cnt >= act_lim);

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         tick_cnt <= 32'h00000000;
         act_cnt  <= 8'h00;
      end
      else if ((state != ST_FULL) | obd_any)
      begin
         tick_cnt <= 32'h00000000;
         act_cnt  <= 8'h00;
      end
      else if (tick_cnt >= TICK_CYC - 1)
      begin
         tick_cnt <= 32'h00000000;
         if (act_cnt != 8'hFF)
            act_cnt <= act_cnt + 8'h01;
      end
      else
         tick_cnt <= tick_cnt + 32'h00000001;
   end

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   reg  [31:0] tmr;
   reg  [31:0] rx_cnt;
   reg         quiet_seen;
   reg         ign_lo_seen;
   wire [31:0] wake_lim;

   assign wake_lim = pwr_cfg[`LPEWC_PWR_WAKE_SEL] ? WAKE_L : WAKE_S;

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         state        <= ST_FULL;
         tmr          <= 32'h00000000;
         rx_cnt       <= 32'h00000000;
         quiet_seen   <= 1'b0;
         ign_lo_seen  <= 1'b0;
         LOW_PWR_O    <= 1'b0;
         BUS_OFF_O    <= 1'b0;
         LOW_POWER_ALERT_MESSAGE_O   <= 1'b0;
         PROT_CLOSE_O <= 1'b0;
         WAKE_RST_O   <= 1'b0;
      end
      else
      begin
         LOW_POWER_ALERT_MESSAGE_O   <= 1'b0;
         PROT_CLOSE_O <= 1'b0;
         WAKE_RST_O   <= 1'b0;
         case (state)
            ST_FULL:
            begin
               tmr <= 32'h00000000;
               if (pwr_cfg[`LPEWC_PWR_MASTER] &
                   ((pwr_cfg[`LPEWC_PWR_IGN_EN] & ign_fall) |
                    (act_en & act_exp)))
               begin
                  state      <= ST_ALERT;
                  LOW_POWER_ALERT_MESSAGE_O <= 1'b1;
               end
            end
            ST_ALERT:
            begin
               if (tmr >= ALERT_CYC - 1)
               begin
                  state       <= ST_LOW;
                  LOW_PWR_O   <= 1'b1;
                  BUS_OFF_O   <= 1'b1;
                  tmr         <= 32'h00000000;
                  rx_cnt      <= 32'h00000000;
                  quiet_seen  <= 1'b0;
                  ign_lo_seen <= 1'b0;
               end
               else
                  tmr <= tmr + 32'h00000001;
            end
            ST_LOW:
            begin
               if (~obd_any)
                  quiet_seen <= 1'b1;
               if (~ign_db)
                  ign_lo_seen <= 1'b1;
               if (rxd_s)
                  rx_cnt <= 32'h00000000;
               else if (rx_cnt < RX_CYC)
                  rx_cnt <= rx_cnt + 32'h00000001;
               if (ign_lo_seen & ign_db)
               begin
                  state <= ST_WAKE;
                  tmr   <= 32'h00000000;
               end
               else if ((quiet_seen & obd_any) |
                        (rx_cnt >= RX_CYC))
               begin
                  state        <= ST_FULL;
                  LOW_PWR_O    <= 1'b0;
                  BUS_OFF_O    <= 1'b0;
                  PROT_CLOSE_O <= 1'b1;
               end
            end
            ST_WAKE:
            begin
               if (tmr >= wake_lim - 32'h00000001)
               begin
                  state        <= ST_FULL;
                  LOW_PWR_O    <= 1'b0;
                  BUS_OFF_O    <= 1'b0;
                  PROT_CLOSE_O <= 1'b1;
                  WAKE_RST_O   <= 1'b1;
               end
               else
                  tmr <= tmr + 32'h00000001;
            end
            default:
            begin
               state     <= ST_FULL;
               LOW_PWR_O <= 1'b0;
               BUS_OFF_O <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Busy and request-to-send handshake
   // ----------------------------------------
   wire abort;

   // Request-to-send held high when unused
   assign abort = busy & ~rts_n_s;

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         busy      <= 1'b0;
         stop_flag <= 1'b0;
         BUSY_O    <= 1'b0;
         STOPPED_O <= 1'b0;
      end
      else
      begin
         STOPPED_O <= abort;
         BUSY_O    <= busy & ~abort;
         if (abort | LOW_PWR_O | (wr_ctl & HWDATA_I[`LPEWC_CTRL_DONE]))
            busy <= 1'b0;
         else if (wr_ctl & HWDATA_I[`LPEWC_CTRL_START])
            busy <= 1'b1;
         if (abort)
            stop_flag <= 1'b1;
         else if (wr_ctl & HWDATA_I[`LPEWC_CTRL_CLR_STOP])
            stop_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Low-power pin overrides
   // ----------------------------------------
   // Voltage select forced low, power control inverted
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         VSEL_O    <= 1'b0;
         PWR_CTL_O <= 1'b0;
      end
      else
      begin
         VSEL_O    <= vsel_sw & ~LOW_PWR_O;
         PWR_CTL_O <= pwr_sw ^ LOW_PWR_O;
      end
   end

endmodule

//--- bench/lpewc_properties.sv
/*
 Port checker of the low-power entry and wake controller.
 Assumes a bind onto lpewc_top with the same shortened counts.
*/
`timescale 1ns/100ps
module lpewc_chk
#(
   parameter integer DEB_CYC   = 4,
   parameter integer ALERT_CYC = 20,
   parameter integer WAKE_S    = 10,
   parameter integer WAKE_L    = 30
)
(
   input wire        MCLK_I,
   input wire        RST_I,
   input wire        HSEL_I,
   input wire [31:0] HADDR_I,
   input wire [1:0]  HTRANS_I,
   input wire        HWRITE_I,
   input wire [31:0] HWDATA_I,
   input wire        HREADY_I,
   input wire        IGN_MON_I,
   input wire        RTS_N_I,
   input wire        RXD_I,
   input wire        BUS_OFF_O,
   input wire        VSEL_O,
   input wire        PWR_CTL_O,
   input wire        BUSY_O,
   input wire        LOW_PWR_O,
   input wire        LOW_POWER_ALERT_MESSAGE_O,
   input wire        STOPPED_O,
   input wire        PROT_CLOSE_O,
   input wire        WAKE_RST_O,
   input wire [15:0] SETTINGS_O,
   input wire [3:0]  PROTOCOL_O,
   input wire [7:0]  BAUD_O
);
// ----------------------------------------
// Shadow of writes and run counters
// ----------------------------------------
reg        wr_pwr;
reg        wr_ctl;
reg        wr_act;
reg [7:0]  act_q;
reg        ctl_pwr;
reg        exp_pwr;
reg [7:0]  pwr_q;
reg [15:0] alert_cnt;
reg [15:0] ign_lo;
reg [15:0] ign_hi;
reg [15:0] rx_lo;
reg [15:0] snap_s;
reg [3:0]  snap_p;
reg [7:0]  snap_b;
wire       acc   = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
wire       start = wr_ctl & HWDATA_I[0];
always @(posedge MCLK_I)
begin
   if (RST_I)
   begin
      wr_pwr <= 1'b0;
      wr_ctl <= 1'b0;
      wr_act <= 1'b0;
      act_q <= 8'h00;
      ctl_pwr <= 1'b0;
      exp_pwr <= 1'b0;
      pwr_q <= 8'h80;
      alert_cnt <= 16'h0000;
      ign_lo <= 16'h0000;
      ign_hi <= 16'h0000;
      rx_lo <= 16'h0000;
   end
   else
   begin
      wr_pwr <= acc & (HADDR_I[7:0] == 8'h00);
      wr_ctl <= acc & (HADDR_I[7:0] == 8'h0C);
      if (wr_pwr)
         pwr_q <= HWDATA_I[7:0];
      wr_act <= acc & (HADDR_I[7:0] == 8'h04);
      if (wr_act)
         act_q <= HWDATA_I[7:0];
      if (wr_ctl)
         ctl_pwr <= HWDATA_I[3];
      exp_pwr <= ctl_pwr ^ LOW_PWR_O;
      alert_cnt <= LOW_POWER_ALERT_MESSAGE_O ? 16'h0001 : alert_cnt + {15'h0000, alert_cnt != 16'h0000};
      ign_lo <= IGN_MON_I ? 16'h0000 : ign_lo + 16'h0001;
      ign_hi <= IGN_MON_I ? ign_hi + 16'h0001 : 16'h0000;
      rx_lo <= (!RXD_I && (LOW_PWR_O || rx_lo != 16'h0000)) ? rx_lo + 16'h0001 : 16'h0000;
      if ($rose(LOW_PWR_O))
      begin
         snap_s <= SETTINGS_O;
         snap_p <= PROTOCOL_O;
         snap_b <= BAUD_O;
      end
   end
end
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking @(posedge MCLK_I); endclocking
default disable iff (RST_I);
sequence s_abort;
   ##[1:5] STOPPED_O ##[0:1] !BUSY_O;
endsequence
sequence s_close;
   ##[0:2] PROT_CLOSE_O;
endsequence
AST_ABORT: assert property (BUSY_O && $fell(RTS_N_I) |-> s_abort)
   else $error("abort not reported");
AST_BUSY_SRC: assert property ($rose(BUSY_O) |-> $past(start, 1) || $past(start, 2))
   else $error("busy rose by itself");
AST_ALERT_DLY: assert property ($rose(LOW_PWR_O) |-> alert_cnt >= ALERT_CYC - 1 && alert_cnt <= ALERT_CYC + 1)
   else $error("low power not 2 s after alert");
AST_BUS_OFF: assert property (LOW_PWR_O |-> BUS_OFF_O)
   else $error("bus outputs on in low power");
AST_RX_WAKE: assert property (rx_lo == 16'h050A |-> !LOW_PWR_O)
   else $error("long rx pulse did not wake");
AST_CLOSE: assert property ($fell(LOW_PWR_O) |-> $past(PROT_CLOSE_O) or s_close)
   else $error("no protocol close on wake");
AST_RETAIN: assert property ($fell(LOW_PWR_O) |-> ##1 (SETTINGS_O == snap_s && PROTOCOL_O == snap_p
   && BAUD_O == snap_b))
   else $error("settings lost over low power");
AST_ENTRY_EN: assert property (LOW_POWER_ALERT_MESSAGE_O |-> pwr_q[7] && (pwr_q[2] || (act_q[7] && act_q[5])))
   else $error("entry while disabled");
AST_IGN_DEB: assert property (LOW_POWER_ALERT_MESSAGE_O && !(act_q[7] && act_q[5]) |-> ign_lo >= DEB_CYC)
   else $error("ignition not debounced");
AST_IGN_WAKE: assert property (WAKE_RST_O |-> ign_hi >= (pwr_q[1] ? WAKE_L : WAKE_S))
   else $error("ignition wake too early");
AST_VSEL_LOW: assert property (LOW_PWR_O && $past(LOW_PWR_O) |-> !VSEL_O)
   else $error("voltage select high in low power");
AST_PWR_INV: assert property (PWR_CTL_O == exp_pwr)
   else $error("power control not inverted in low power");
endmodule

//--- bench/lpewc_host.sv
/*
 Host processor model on the serial and handshake lines.
 Assumes calls from the bench right after a rising clock edge.
*/
`timescale 1ns/100ps
module lpewc_host
(
   input  wire clk_i,
   input  wire busy_i,
   output reg  rts_n_o,
   output reg  rxd_o
);
initial
begin
   rts_n_o = 1'b1;
   rxd_o = 1'b1;
end
task automatic abort(input int lag);
   begin
      repeat (lag) @(posedge clk_i);
      if (busy_i === 1'b1)
      begin
         rts_n_o <= 1'b0;
         for (int i = 0; i < 50 && busy_i !== 1'b0; i++)
            @(posedge clk_i);
         rts_n_o <= 1'b1;
      end
   end
endtask
task automatic rx_low(input int len);
   begin
      rxd_o <= 1'b0;
      repeat (len) @(posedge clk_i);
      rxd_o <= 1'b1;
   end
endtask
endmodule

//--- bench/tb.sv
/*
 Self-checking bench of the low-power entry and wake controller.
 Assumes host model and checker compiled first.
*/
`timescale 1ns/100ps
module tb;
localparam integer DEB_CYC   = 4;
localparam integer ALERT_CYC = 20;
localparam integer WAKE_S    = 10;
localparam integer WAKE_L    = 30;
reg         mclk, rst, hsel, hwrite, ign, rdp;
reg  [31:0] haddr, hwdata, seed;
reg  [1:0]  htrans;
reg  [2:0]  hsize;
reg  [3:0]  obd;
reg  [27:0] snap;
reg  [31:0] exp_q[$];
reg  [31:0] msk_q[$];
wire [31:0] hrdata;
wire        hready, hresp, rts_n, rxd, bus_off, vsel, pwr_ctl, busy, low_pwr;
wire        alert, stopped, pclose, wrst;
wire [15:0] sets;
wire [3:0]  prot;
wire [7:0]  baud;
integer     mismatches, checks, alerts, closes, stops, wrsts, n, m, k, t, w;
lpewc_top #(.DEB_CYC(DEB_CYC), .ALERT_CYC(ALERT_CYC), .WAKE_S(WAKE_S), .WAKE_L(WAKE_L), .TICK_CYC(8)) dut_u
(
   .MCLK_I(mclk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
   .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
   .HRESP_O(hresp), .IGN_MON_I(ign), .RTS_N_I(rts_n), .RXD_I(rxd), .OBD_ACT_I(obd), .BUS_OFF_O(bus_off),
   .VSEL_O(vsel), .PWR_CTL_O(pwr_ctl), .BUSY_O(busy), .LOW_PWR_O(low_pwr), .LOW_POWER_ALERT_MESSAGE_O(alert),
   .STOPPED_O(stopped), .PROT_CLOSE_O(pclose), .WAKE_RST_O(wrst), .SETTINGS_O(sets), .PROTOCOL_O(prot),
   .BAUD_O(baud)
);
lpewc_host host_u (.clk_i(mclk), .busy_i(busy), .rts_n_o(rts_n), .rxd_o(rxd));
initial
begin
   mclk = 1'b0;
   forever #50 mclk = ~mclk;
end
function [31:0] lfsr(input [31:0] s);
   lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task automatic chk(input logic ok, input string msg);
   begin
      checks = checks + 1;
      if (ok !== 1'b1)
      begin
         mismatches = mismatches + 1;
         $display("ERROR %0t: %s", $time, msg);
      end
   end
endtask
// ----------------------------------------
// AHB-Lite single word transfer
// ----------------------------------------
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] msk);
   begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdp <= !w;
      if (!w)
      begin
         exp_q.push_back(d);
         msk_q.push_back(msk);
      end
      do @(posedge mclk); while (hready !== 1'b1);
      rdp <= 1'b0;
   end
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
   xfer(1'b1, a, d, 32'h00000000);
endtask
always @(posedge mclk)
begin
   if (rdp === 1'b1 && hready === 1'b1)
   begin
      chk(((hrdata ^ exp_q[0]) & msk_q[0]) === 32'h00000000 && hresp === 1'b0, "read data");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
   end
   alerts = alerts + (alert === 1'b1);
   closes = closes + (pclose === 1'b1);
   stops = stops + (stopped === 1'b1);
   wrsts = wrsts + (wrst === 1'b1);
end
task enter;
   begin
      ign <= 1'b1;
      repeat (20) @(posedge mclk);
      wr(8'h00, 32'h00000084);
      ign <= 1'b0;
      for (n = 0; n < 100 && low_pwr !== 1'b1; n++)
         @(posedge mclk);
      chk(low_pwr === 1'b1 && bus_off === 1'b1, "no entry");
      wr(8'h00, (k == 3) ? 32'h00000080 : 32'h00000082);
      chk(vsel === 1'b0 && pwr_ctl === 1'b0, "pins in low power");
   end
endtask
task close_out;
   begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
endtask
initial
begin
   #2000000;
   mismatches = mismatches + 1;
   close_out;
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
   {mismatches, checks, alerts, closes, stops, wrsts} = 0;
   {rst, ign} = 2'h3;
   {hsel, hwrite, rdp, htrans, obd, haddr, hwdata} = 0;
   hsize = 3'h2;
   seed = 32'h00003F7E;
   repeat (3) @(posedge mclk);
   rst <= 1'b0;
   @(posedge mclk);
   xfer(1'b0, 8'h00, 32'h00000080, 32'h000000FF);
   xfer(1'b0, 8'h04, 32'h00000000, 32'h000000FF);
   xfer(1'b0, 8'h18, 32'h00000000, 32'hFFFFFFFF);
   seed = lfsr(seed);
   wr(8'h14, seed);
   xfer(1'b0, 8'h14, seed, 32'h0FFFFFFF);
   snap = seed[27:0];
   wr(8'h0C, 32'h00000001);
   repeat (3) @(posedge mclk);
   chk(busy === 1'b1, "not busy");
   m = stops;
   host_u.abort(2);
   repeat (4) @(posedge mclk);
   chk(busy === 1'b0 && stops == m + 1, "no abort");
   xfer(1'b0, 8'h10, 32'h00000008, 32'h0000000C);
   wr(8'h0C, 32'h00000010);
   repeat (200) @(posedge mclk);
   chk(busy === 1'b0, "busy again");
   wr(8'h0C, 32'h00000001);
   wr(8'h0C, 32'h0000000E);
   repeat (3) @(posedge mclk);
   chk(busy === 1'b0, "still busy");
   for (k = 0; k < 2; k++)
   begin
      wr(8'h08, k ? 32'h00000000 : 32'h00000001);
      wr(8'h04, k ? 32'h000000B0 : 32'h00000030);
      m = alerts;
      repeat (1000) @(posedge mclk);
      chk(alerts == m, "activity entry");
   end
   wr(8'h04, 32'h00000000);
   ign <= 1'b0;
   repeat (20) @(posedge mclk);
   chk(alerts == m, "entry while disabled");
   xfer(1'b0, 8'h10, 32'h00000000, 32'h00000002);
   ign <= 1'b1;
   repeat (20) @(posedge mclk);
   xfer(1'b0, 8'h10, 32'h00000002, 32'h00000002);
   wr(8'h00, 32'h00000084);
   ign <= 1'b0;
   repeat (2) @(posedge mclk);
   ign <= 1'b1;
   repeat (30) @(posedge mclk);
   chk(alerts == m, "glitch accepted");
   for (k = 0; k < 4; k++)
   begin
      enter;
      n = closes;
      m = wrsts;
      if (k == 0)
      begin
         host_u.rx_low(1000);
         repeat (20) @(posedge mclk);
         chk(low_pwr === 1'b1, "short pulse woke");
         host_u.rx_low(1300);
      end
      if (k == 1)
         obd <= 4'h2;
      if (k >= 2)
         ign <= 1'b1;
      for (t = 0; t < 200 && low_pwr !== 1'b0; t++)
         @(posedge mclk);
      chk(low_pwr === 1'b0, "no wake");
      repeat (3) @(posedge mclk);
      chk(closes == n + 1 && {baud, prot, sets} === snap, "settings");
      chk(vsel === 1'b1 && pwr_ctl === 1'b1, "pins after wake");
      obd <= 4'h0;
      w = (k == 2) ? WAKE_L : WAKE_S;
      if (k >= 2)
         chk(wrsts == m + 1 && t >= w + DEB_CYC && t <= w + DEB_CYC + 6, "ignition wake");
   end
   close_out;
end
endmodule
bind lpewc_top lpewc_chk #(.DEB_CYC(DEB_CYC), .ALERT_CYC(ALERT_CYC), .WAKE_S(WAKE_S), .WAKE_L(WAKE_L)) chk_u
(
   .MCLK_I(MCLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
   .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .IGN_MON_I(IGN_MON_I),
   .RTS_N_I(RTS_N_I), .RXD_I(RXD_I), .BUS_OFF_O(BUS_OFF_O), .VSEL_O(VSEL_O), .PWR_CTL_O(PWR_CTL_O),
   .BUSY_O(BUSY_O), .LOW_PWR_O(LOW_PWR_O),
   .LOW_POWER_ALERT_MESSAGE_O(LOW_POWER_ALERT_MESSAGE_O), .STOPPED_O(STOPPED_O), .PROT_CLOSE_O(PROT_CLOSE_O), .WAKE_RST_O(WAKE_RST_O),
   .SETTINGS_O(SETTINGS_O), .PROTOCOL_O(PROTOCOL_O), .BAUD_O(BAUD_O)
);
